/* File: verilog/pwm_channel_consts.svh */
// Register offsets, field positions and reset values of the PWM channel core.
// Assumes inclusion by bare name from the package and design file.
`ifndef PWM_CHANNEL_CONSTS_SVH
`define PWM_CHANNEL_CONSTS_SVH

`define PWM_OFS_CTRL    12'h000
`define PWM_OFS_PERIOD  12'h004
`define PWM_OFS_DUTY    12'h008
`define PWM_OFS_COUNT   12'h00C
`define PWM_OFS_STATUS  12'h010
`define PWM_OFS_PRESC   12'h014

`define PWM_BIT_ENABLE  0
`define PWM_BIT_POL     1
`define PWM_BIT_CENTER  2

`define PWM_RST_PERIOD  8'hFF
`define PWM_RST_DUTY    8'h00
`define PWM_RST_PRESC   8'h00
`define PWM_CNT_ZERO    8'h00
`define PWM_ONE8        8'h01
`define PWM_ADDR_W      12

`endif

/* File: verilog/pwm_channel_pkg.sv */
// Types shared by the PWM channel core.
// Assumes the constants header sits beside it.
`include "pwm_channel_consts.svh"
package pwm_channel_pkg;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_type;

  typedef enum logic {
    DIR_UP,
    DIR_DOWN
  } count_dir_type;
endpackage

/* File: verilog/pwm_channel_core.sv */
// One 8-bit PWM channel with APB register access.
// Assumes a single 250 MHz clock and APB master in the same domain.
//
// What this block does
// - Selected clock reaches the channel only while its enable is set.
// - Enable acts only at a clock tick edge, never mid-pulse; disable acts at once.
// - Counter holds still while the channel is disabled.
// - Polarity one: output starts high, goes low at duty match.
// - Polarity zero: output starts low, goes high at duty match.
// - Period and duty buffered; load at period end, counter write, or disable.
// - Counter write clears count and latches buffered period and duty.
// - While disabled, period and duty writes reach buffer and latch together.
// - Software can read the live counter value at any time.
// - Own 8-bit up/down counter advancing at the selected clock rate.
// - Duty match toggles the output flip-flop.
// - Period match handled per alignment mode, left or center.
//
// Register map, one 32-bit word each, data in the low bits:
//   CTRL   0x000  bit0 enable, bit1 polarity, bit2 center alignment
//   PERIOD 0x004  buffered period, reads back the buffer
//   DUTY   0x008  buffered duty, reads back the buffer
//   COUNT  0x00C  live count; any write clears it and reloads the latches
//   STATUS 0x010  bit0 gated enable, bit1 counting down, bit2 raw flop
//   PRESC  0x014  selected clock divider, one tick every value+1 clocks
//
// Bus behaviour:
//   Zero wait states: pready is high in the first access cycle.
//   Unmapped reads return zero, writes there are ignored, no error.
//   Period and duty read back the buffer, not the active latch.
//
// Limitations:
//   Left mode runs period+1 ticks per cycle; center mode 2*period.
//   The first phase lasts duty+1 ticks, since the flop changes
//   on the tick after the match has been seen.
//   A duty above the period leaves the output at its start level.
//   Divider changes do not restart the tick phase.
`include "pwm_channel_consts.svh"
module pwm_channel_core #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic                       CLK,
  input  wire logic                       ARST_N,
  // APB slave
  input  wire pwm_channel_pkg::apb_req_type APB_REQ,
  output      pwm_channel_pkg::apb_rsp_type APB_RSP,
  // Waveform
  output      logic                       PWM_OUT
);
  import pwm_channel_pkg::*;

  // Buffered and active compare values
  logic [WIDTH-1:0] period_buf;
  logic [WIDTH-1:0] duty_buf;
  logic [WIDTH-1:0] period_act;
  logic [WIDTH-1:0] duty_act;

  // Counter, prescaler and direction
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] presc;
  logic [WIDTH-1:0] presc_cnt;
  count_dir_type    dir;
  logic             tick;

  // Control fields and gated enable
  logic             enable;
  logic             polarity;
  logic             center;
  logic             gate_en;

  // Waveform flip-flop
  logic             out_ff;

  // Decoded bus strobes
  logic             bus_wr;
  logic             wr_ctrl;
  logic             wr_presc;
  logic             wr_count;
  logic             wr_period;
  logic             wr_duty;

  // Compare results, cycle bookkeeping and read data
  logic             period_hit;
  logic             duty_hit;
  logic             cycle_end;
  logic             load_act;
  logic [2:0]       status_bits;
  logic [31:0]      next_rdata;

  // Address match helper
  function automatic logic hit(input logic [`PWM_ADDR_W-1:0] a,
                               input logic [`PWM_ADDR_W-1:0] ofs);
    return a == ofs;
  endfunction

  // Zero extension of a register field onto the 32-bit read bus
  function automatic logic [31:0] zext(input logic [WIDTH-1:0] v);
    return {{(32-WIDTH){1'b0}}, v};
  endfunction

  // One count step up or down, wrapping at the counter width
  function automatic logic [WIDTH-1:0] step(input logic [WIDTH-1:0] v,
                                            input count_dir_type d);
    return (d == DIR_UP) ? v + `PWM_ONE8 : v - `PWM_ONE8;
  endfunction

  // APB strobes, one per completed access
  // The access cycle is the one in which the registered pready is high,
  // so a write lands on the same edge at which the master sees ready.
  assign bus_wr    = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite;
  assign wr_ctrl   = bus_wr && hit(APB_REQ.paddr, `PWM_OFS_CTRL);
  assign wr_presc  = bus_wr && hit(APB_REQ.paddr, `PWM_OFS_PRESC);
  assign wr_count  = bus_wr && hit(APB_REQ.paddr, `PWM_OFS_COUNT);
  assign wr_period = bus_wr && hit(APB_REQ.paddr, `PWM_OFS_PERIOD);
  assign wr_duty   = bus_wr && hit(APB_REQ.paddr, `PWM_OFS_DUTY);

  // Control register
  // Enable is only a request here; the gate below decides when it acts
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      enable   <= 1'b0;
      polarity <= 1'b0;
      center   <= 1'b0;
    end else if (wr_ctrl) begin
      enable   <= APB_REQ.pwdata[`PWM_BIT_ENABLE];
      polarity <= APB_REQ.pwdata[`PWM_BIT_POL];
      center   <= APB_REQ.pwdata[`PWM_BIT_CENTER];
    end
  end

  // Prescaler select register
  // A new divider applies at once; the prescaler count is not restarted
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      presc <= `PWM_RST_PRESC;
    end else if (wr_presc) begin
      presc <= APB_REQ.pwdata[WIDTH-1:0];
    end
  end

  // Selected clock: one tick every presc+1 module clocks
  // With a zero divider the tick is high on every clock
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      presc_cnt <= `PWM_CNT_ZERO;
    end else if (presc_cnt >= presc) begin
      presc_cnt <= `PWM_CNT_ZERO;
    end else begin
      presc_cnt <= presc_cnt + `PWM_ONE8;
    end
  end
  assign tick = presc_cnt >= presc;

  // Enable gate opens only on a tick edge, closes at once
  // Disable acts at once; enable waits for a tick, so no short first tick
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      gate_en <= 1'b0;
    end else if (tick || !enable) begin
      gate_en <= enable;
    end
  end

  // Compare results shared by counter and output logic
  assign period_hit = count >= period_act;
  assign duty_hit   = count == duty_act;

  // End of effective period
  // Center mode ends a cycle as the down count leaves one for zero
  always_comb begin
    if (center) begin
      cycle_end = dir == DIR_DOWN && count == `PWM_ONE8;
    end else begin
      cycle_end = period_hit;
    end
  end
  // Latches follow the buffer while the gate is closed
  assign load_act = wr_count || !gate_en || (gate_en && tick && cycle_end);

  // Buffered period and duty
  // Buffers always take bus writes, enabled or not
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      period_buf <= `PWM_RST_PERIOD;
      duty_buf   <= `PWM_RST_DUTY;
    end else begin
      if (wr_period) begin
        period_buf <= APB_REQ.pwdata[WIDTH-1:0];
      end
      if (wr_duty) begin
        duty_buf <= APB_REQ.pwdata[WIDTH-1:0];
      end
    end
  end

  // Active latches
  // A write while the gate is closed bypasses the buffer in the same cycle
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      period_act <= `PWM_RST_PERIOD;
      duty_act   <= `PWM_RST_DUTY;
    end else if (!gate_en) begin
      period_act <= wr_period ? APB_REQ.pwdata[WIDTH-1:0] : period_buf;
      duty_act   <= wr_duty ? APB_REQ.pwdata[WIDTH-1:0] : duty_buf;
    end else if (load_act) begin
      period_act <= period_buf;
      duty_act   <= duty_buf;
    end
  end

  // Up/down counter and direction
  // A counter write wins over a tick landing in the same cycle
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      count <= `PWM_CNT_ZERO;
      dir   <= DIR_UP;
    end else if (wr_count) begin
      count <= `PWM_CNT_ZERO;
      dir   <= DIR_UP;
    end else if (gate_en && tick) begin
      if (!center) begin
        // Left mode: always up, back to zero after the period match
        dir   <= DIR_UP;
        count <= cycle_end ? `PWM_CNT_ZERO : step(count, DIR_UP);
      end else if (dir == DIR_UP) begin
        // Center mode: turn round at the period match
        if (period_hit) begin
          dir   <= DIR_DOWN;
          count <= step(count, DIR_DOWN);
        end else begin
          count <= step(count, DIR_UP);
        end
      end else begin
        // Center mode: the down leg ends by returning to zero
        if (count == `PWM_CNT_ZERO || cycle_end) begin
          dir   <= DIR_UP;
          count <= `PWM_CNT_ZERO;
        end else begin
          count <= step(count, DIR_DOWN);
        end
      end
    end
  end

  // Output flip-flop: start level at cycle start, toggle on duty match
  // Start level is restored at cycle end, counter write or while gated
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      out_ff <= 1'b0;
    end else if (!gate_en || wr_count || (tick && cycle_end)) begin
      out_ff <= 1'b0;
    end else if (tick && duty_hit) begin
      out_ff <= ~out_ff;
    end
  end

  // Polarity mux onto the pin
  // Extra flop keeps the pin glitch free at the cost of one clock of delay
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PWM_OUT <= 1'b0;
    end else begin
      PWM_OUT <= polarity ? ~out_ff : out_ff;
    end
  end

  // Status word: raw flop, direction and gated enable
  assign status_bits = {out_ff, dir == DIR_DOWN, gate_en};

  // Read mux
  // Decoded from the setup cycle address, registered for the access cycle
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (APB_REQ.paddr)
      `PWM_OFS_CTRL:   next_rdata = {29'h0, center, polarity, enable};
      `PWM_OFS_PERIOD: next_rdata = zext(period_buf);
      `PWM_OFS_DUTY:   next_rdata = zext(duty_buf);
      `PWM_OFS_COUNT:  next_rdata = zext(count);
      `PWM_OFS_STATUS: next_rdata = {29'h0, status_bits};
      `PWM_OFS_PRESC:  next_rdata = zext(presc);
      default:         next_rdata = 32'h0000_0000;
    endcase
  end

  // APB answer: ready in the first cycle of the access phase
  // Read data is zero on writes so the bus never shows stale values
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      APB_RSP <= '0;
    end else begin
      APB_RSP.pready  <= APB_REQ.psel && !APB_REQ.penable;
      APB_RSP.pslverr <= 1'b0;
      APB_RSP.prdata  <= (APB_REQ.psel && !APB_REQ.pwrite) ? next_rdata : 32'h0000_0000;
    end
  end
endmodule

/* File: test/pwm_channel_core_assertions.sv */
// Port checker for the PWM channel core.
// Assumes binding onto pwm_channel_core, zero wait state APB.
`include "pwm_channel_consts.svh"
module pwm_channel_core_assertions (
  // Clock, reset, bus and waveform
  input wire logic                         CLK,
  input wire logic                         ARST_N,
  input wire pwm_channel_pkg::apb_req_type APB_REQ,
  input wire pwm_channel_pkg::apb_rsp_type APB_RSP,
  input wire logic                         PWM_OUT
);
  import pwm_channel_pkg::*;
  logic       wr;
  logic       rd;
  logic       wc;
  logic       en;
  logic       pol;
  logic       zero;
  logic [7:0] per;
  logic [1:0] since;
  // Completed transfers
  assign wr = APB_RSP.pready && APB_REQ.pwrite;
  assign rd = APB_RSP.pready && !APB_REQ.pwrite;
  assign wc = wr && APB_REQ.paddr == `PWM_OFS_CTRL;
  // Shadow of written control, period and count state
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      en <= 1'b0;
      pol <= 1'b0;
      zero <= 1'b0;
      per <= `PWM_RST_PERIOD;
      since <= 2'h3;
    end else begin
      if (wc) begin
        en <= APB_REQ.pwdata[`PWM_BIT_ENABLE];
        pol <= APB_REQ.pwdata[`PWM_BIT_POL];
      end
      since <= wc ? 2'h0 : (since == 2'h3 ? since : since + 2'h1);
      zero <= wc ? 1'b0 : (zero || (wr && APB_REQ.paddr == `PWM_OFS_COUNT && !en));
      if (wr && APB_REQ.paddr == `PWM_OFS_PERIOD) per <= APB_REQ.pwdata[7:0];
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  property p_zero_wait; APB_REQ.psel && APB_REQ.penable && !$past(APB_REQ.penable) |-> APB_RSP.pready; endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("ready late");
  property p_ready_once; APB_RSP.pready |=> !APB_RSP.pready; endproperty
  a_ready_once: assert property (p_ready_once) else $error("ready held");
  property p_ready_qual; APB_RSP.pready |-> APB_REQ.psel && APB_REQ.penable; endproperty
  a_ready_qual: assert property (p_ready_qual) else $error("stray ready");
  property p_no_err; APB_RSP.pslverr == 1'b0; endproperty
  a_no_err: assert property (p_no_err) else $error("slave error");
  property p_unmapped; rd && APB_REQ.paddr > `PWM_OFS_PRESC |-> APB_RSP.prdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped data");
  property p_dis_level; !en && since == 2'h3 |-> PWM_OUT == pol; endproperty
  a_dis_level: assert property (p_dis_level) else $error("idle level");
  property p_cnt_clear; rd && zero && APB_REQ.paddr == `PWM_OFS_COUNT |-> APB_RSP.prdata == 32'h0; endproperty
  a_cnt_clear: assert property (p_cnt_clear) else $error("count moved");
  property p_per_rb; rd && APB_REQ.paddr == `PWM_OFS_PERIOD |-> APB_RSP.prdata == {24'h0, per}; endproperty
  a_per_rb: assert property (p_per_rb) else $error("period readback");
  c_cnt_write: cover property (wr && APB_REQ.paddr == `PWM_OFS_COUNT);
  c_per_read: cover property (rd && APB_REQ.paddr == `PWM_OFS_PERIOD);
  c_wave: cover property (en && $rose(PWM_OUT));
endmodule
bind pwm_channel_core pwm_channel_core_assertions i_chk (.CLK(CLK), .ARST_N(ARST_N),
  .APB_REQ(APB_REQ), .APB_RSP(APB_RSP), .PWM_OUT(PWM_OUT));

/* File: test/pwm_channel_core_tb_top.sv */
// Directed bench for the PWM channel core over APB.
// Assumes the design files and the checker are compiled first.
`include "pwm_channel_consts.svh"
module pwm_channel_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pwm_channel_pkg::*;
  logic        clk;
  logic        arst_n;
  apb_req_type req;
  apb_rsp_type rsp;
  logic        pwm;
  logic [31:0] q;
  int          err_total;
  int          checks;
  // Device under test
  pwm_channel_core i_dut (.CLK(clk), .ARST_N(arst_n), .APB_REQ(req), .APB_RSP(rsp),
    .PWM_OUT(pwm));
  // Clock at 250 MHz
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, waits for pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    q = rsp.prdata;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge clk);
    if (n >= 20) err_total++;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  // High clocks of the waveform over a whole number of periods
  task automatic meas(input logic [7:0] ps, input logic [7:0] ctl, input int win, input int exp);
    int hi;
    apb(1'b1, `PWM_OFS_PRESC, {24'h0, ps});
    apb(1'b1, `PWM_OFS_CTRL, {24'h0, ctl});
    repeat (40) @(posedge clk);
    hi = 0;
    repeat (win) begin
      @(posedge clk);
      hi += (pwm === 1'b1);
    end
    chk(hi, exp);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic t_reset();
    rd(`PWM_OFS_CTRL, 32'h0);
    rd(`PWM_OFS_PERIOD, 32'hFF);
    rd(`PWM_OFS_DUTY, 32'h0);
    rd(12'h100, 32'h0);
    chk({31'h0, pwm}, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_disabled();
    apb(1'b1, `PWM_OFS_PERIOD, 32'h9);
    apb(1'b1, `PWM_OFS_DUTY, 32'h3);
    apb(1'b1, `PWM_OFS_COUNT, 32'h5A);
    rd(`PWM_OFS_COUNT, 32'h0);
    rd(`PWM_OFS_COUNT, 32'h0);
    apb(1'b1, `PWM_OFS_CTRL, 32'h2);
    repeat (3) @(posedge clk);
    chk({31'h0, pwm}, 32'h1);
    $display("disabled test done");
  endtask
  task automatic t_wave();
    meas(8'h0, 8'h3, 100, 40);
    meas(8'h0, 8'h1, 100, 60);
    meas(8'h1, 8'h3, 200, 80);
    meas(8'h0, 8'h7, 90, 30);
    $display("waveform test done");
  endtask
  task automatic t_buffer();
    apb(1'b1, `PWM_OFS_CTRL, 32'h3);
    apb(1'b1, `PWM_OFS_DUTY, 32'h6);
    rd(`PWM_OFS_DUTY, 32'h6);
    apb(1'b1, `PWM_OFS_COUNT, 32'h0);
    rd(`PWM_OFS_COUNT, 32'h1);
    meas(8'h0, 8'h3, 100, 70);
    $display("buffer test done");
  endtask
  // Watchdog
  initial begin
    #200000;
    err_total++;
    finish_test();
  end
  // Main sequence
  initial begin
    err_total = 0;
    checks = 0;
    req = '0;
    arst_n = 1'b0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_disabled();
    t_wave();
    t_buffer();
    finish_test();
  end
endmodule
